// >>> hdl/pda_adapter.sv
`timescale 1ns/1ps
// adapter end: raises requests, answers only when its acknowledge is active
module pda_adapter (
   pda_bus_if.adapter  bus,         // link side
   input  wire logic        clock,       // user clock
   input  wire logic        rst_b,       // user reset, synchronous active low
   input  wire logic [7:0]  want,        // user: channels wanting service, level
   input  wire logic [15:0] wr_data,     // user: data supplied on transfers
   output logic [7:0]       xfer_pulse,  // user: one pulse per finished transfer
   output logic [7:0]       tc_pulse,    // user: terminal count seen on channel
   output logic             refresh_seen // user: refresh line seen low, level
);

   // ****************************************
   // link side
   // ****************************************
   logic [7:0] req_reg, req_next;
   logic [7:0] done_tgl_reg, done_tgl_next;
   logic [7:0] tc_tgl_reg, tc_tgl_next;
   logic       strobe_d_reg, strobe_d_next;
   logic       tc_d_reg, tc_d_next;
   logic [1:0] want_s_reg [8];
   logic [1:0] ref_s_reg;
   logic       strobe;
   logic [7:0] ack;

   assign ack    = ~bus.dack_n & pda_pkg::CH_PRESENT;
   assign strobe = ~bus.ior_n | ~bus.iow_n;

   // request lines driven only when asserting, released otherwise
   assign bus.drq_o    = req_reg;
   assign bus.drq_oe   = req_reg;
   assign bus.master_n = 1'b1;             // never takes the bus
   assign bus.data     = wr_data;

   // level crossing of user wants into link domain
   always_ff @(posedge bus.link_clk) begin
      for (int i = 0; i < 8; i++) begin
         want_s_reg[i] <= bus.bus_reset ? pda_pkg::SYNC_RST : {want_s_reg[i][0], want[i]};
      end
   end

   // transfer recognised by strobe plus own acknowledge, not by address
   always_comb begin
      req_next      = req_reg;
      done_tgl_next = done_tgl_reg;
      tc_tgl_next   = tc_tgl_reg;
      strobe_d_next = strobe;
      // terminal count falls with the strobe, so keep what the strobe carried
      tc_d_next     = strobe & bus.tc;
      for (int i = 0; i < 8; i++) begin
         req_next[i] = want_s_reg[i][1] & pda_pkg::CH_PRESENT[i];
         // aen high: only the acknowledged channel reacts
         if (strobe_d_reg && !strobe && ack[i] && bus.aen) begin
            done_tgl_next[i] = ~done_tgl_reg[i];
            if (tc_d_reg) begin
               tc_tgl_next[i] = ~tc_tgl_reg[i];
            end
         end
      end
      if (bus.bus_reset) begin
         req_next      = 8'h00;
         done_tgl_next = 8'h00;
         tc_tgl_next   = 8'h00;
         strobe_d_next = 1'b0;
         tc_d_next     = 1'b0;
      end
   end

   always_ff @(posedge bus.link_clk) begin
      req_reg      <= req_next;
      done_tgl_reg <= done_tgl_next;
      tc_tgl_reg   <= tc_tgl_next;
      strobe_d_reg <= strobe_d_next;
      tc_d_reg     <= tc_d_next;
   end

   // ****************************************
   // user side
   // ****************************************
   logic [2:0] done_s_reg [8];
   logic [2:0] tcs_s_reg [8];

   // toggle crossing; third stage gives the edge detector a clean pair
   always_ff @(posedge clock) begin
      for (int i = 0; i < 8; i++) begin
         done_s_reg[i] <= !rst_b ? 3'h0 : {done_s_reg[i][1:0], done_tgl_reg[i]};
         tcs_s_reg[i]  <= !rst_b ? 3'h0 : {tcs_s_reg[i][1:0], tc_tgl_reg[i]};
      end
      ref_s_reg <= !rst_b ? pda_pkg::SYNC_RST : {ref_s_reg[0], ~bus.refresh_n};
   end

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         xfer_pulse[i] = done_s_reg[i][2] ^ done_s_reg[i][1];
         tc_pulse[i]   = tcs_s_reg[i][2] ^ tcs_s_reg[i][1];
      end
   end
   assign refresh_seen = ref_s_reg[1];

endmodule

// >>> hdl/pda_bus_if.sv
`timescale 1ns/1ps
// shared dma arbitration wires; tri-state lines resolved here from enables
interface pda_bus_if;
   logic       link_clk;      // bus clock, made by the master
   logic       bus_reset;     // reset drive to adapters, active high
   logic [7:0] drq_o;         // adapter request drive value
   logic [7:0] drq_oe;        // adapter request drive enable
   logic [7:0] drq;           // resolved request lines
   logic [7:0] dack_n;        // acknowledges, always driven by master
   logic       aen;           // address enable
   logic       bale;          // address latch enable
   logic       tc;            // terminal count
   logic       ior_n;         // i/o read strobe
   logic       iow_n;         // i/o write strobe
   logic       refresh_n_o;   // master refresh drive value
   logic       refresh_n_oe;  // master refresh drive enable
   logic       refresh_n;     // resolved refresh line
   logic       master_n;      // alternate master request, unused
   logic [15:0] data;         // transfer data from the adapter

   // undriven request lines read low, refresh line has a pull-up
   assign drq       = drq_o & drq_oe;
   assign refresh_n = refresh_n_oe ? refresh_n_o : 1'b1;

   modport master (output link_clk, output bus_reset, input drq, output dack_n, output aen, output bale,
                   output tc, output ior_n, output iow_n, output refresh_n_o, output refresh_n_oe,
                   input refresh_n, input master_n, input data);
   modport adapter (input link_clk, input bus_reset, output drq_o, output drq_oe, input dack_n, input aen,
                    input bale, input tc, input ior_n, input iow_n, input refresh_n, output master_n,
                    output data);
endinterface

// >>> hdl/pda_master.sv
`timescale 1ns/1ps
// What this block does
// - channels 0-3 byte, 5-7 halfword transfers
// - adapters raise requests through tri-state drivers
// - master samples every request line continuously
// - acknowledge low grants; acknowledges always driven
// - address enable high while dma owns addresses
// - adapters ignore i/o decode while enabled
// - current master pulls refresh low, tri-state
// - terminal count raised during final command strobe
// - adapters honour terminal count only when acknowledged
// - alternate master line ignored, never granted
// - latch enable held high through whole transfer
// - adapters decode strobe plus acknowledge, not address
module pda_master #(
   parameter int DIV = 2                       // link clock = clock / (2*DIV)
) (
   pda_bus_if.master         bus,          // link side
   input  wire logic         clock,        // system clock, 50 MHz
   input  wire logic         rst_b,        // synchronous active low reset
   input  wire logic [7:0]   chan_en,      // user: channels enabled for service
   input  wire logic [15:0]  xfer_count,   // user: transfers per grant minus one
   input  wire logic         read_dir,     // user: 1 = i/o read strobe, 0 = i/o write
   input  wire logic         refresh_req,  // user: request a refresh cycle, level
   output logic [2:0]        active_ch,    // user: channel granted, 4 when none
   output logic [15:0]       last_data,    // user: last word read from adapter
   output logic              busy          // user: dma or refresh in progress
);

   // divider counter is eight bits wide
   if (DIV < 1 || DIV > 255) begin : g_div_check
      $error("pda_master: DIV out of range");
   end

   // ****************************************
   // link clock divider and reset drive
   // ****************************************
   logic [7:0] div_reg, div_next;
   logic       lclk_reg, lclk_next;

   // the master makes the bus clock, so it is not a second domain here
   always_comb begin
      div_next  = div_reg + 8'h01;
      lclk_next = lclk_reg;
      if (div_reg == 8'(DIV - 1)) begin
         div_next  = 8'h00;
         lclk_next = ~lclk_reg;
      end
      if (!rst_b) begin
         div_next  = 8'h00;
         lclk_next = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      div_reg  <= div_next;
      lclk_reg <= lclk_next;
   end

   // bus outputs move as the link clock falls, so adapters sample them settled on the rise
   logic lclk_fall;
   assign lclk_fall    = (div_reg == 8'(DIV - 1)) && lclk_reg;
   assign bus.link_clk = lclk_reg;

   logic [2:0] rdrv_reg, rdrv_next;
   logic       rdrv_on_reg, rdrv_on_next;

   // link clock stands still in reset, so adapters need the drive to outlast rst_b
   always_comb begin
      rdrv_next = rdrv_reg;
      if (lclk_fall && rdrv_reg != pda_pkg::RSTDRV_CNT) begin
         rdrv_next = rdrv_reg + 3'h1;
      end
      rdrv_on_next = rdrv_next != pda_pkg::RSTDRV_CNT;
      if (!rst_b) begin
         rdrv_next    = 3'h0;
         rdrv_on_next = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      rdrv_reg    <= rdrv_next;
      rdrv_on_reg <= rdrv_on_next;
   end

   // ****************************************
   // request sampling
   // ****************************************
   logic [7:0] drq_s1_reg, drq_s2_reg;
   logic [7:0] drq_s1_next, drq_s2_next;

   // requests come from adapters on their own timing: two flops first
   always_comb begin
      drq_s1_next = rst_b ? bus.drq : 8'h00;
      drq_s2_next = rst_b ? drq_s1_reg : 8'h00;
   end

   always_ff @(posedge clock) begin
      drq_s1_reg <= drq_s1_next;
      drq_s2_reg <= drq_s2_next;
   end

   logic [7:0] pending;
   assign pending = drq_s2_reg & chan_en & pda_pkg::CH_PRESENT;

   // fixed priority, lowest channel first
   function automatic logic [2:0] pick(input logic [7:0] p);
      logic [2:0] r;
      r = pda_pkg::CH_NONE;
      for (int i = 7; i >= 0; i--) begin
         if (p[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

   // ****************************************
   // transfer sequencer
   // ****************************************
   pda_pkg::pda_state_e st_reg, st_next;
   logic [2:0]  ch_reg, ch_next;
   logic [15:0] cnt_reg, cnt_next;
   logic [1:0]  stb_reg, stb_next;
   logic [15:0] data_reg, data_next;
   logic        dir_reg, dir_next;

   // master_n is deliberately never read: no takeover path exists
   always_comb begin
      st_next   = st_reg;
      ch_next   = ch_reg;
      cnt_next  = cnt_reg;
      stb_next  = stb_reg;
      data_next = data_reg;
      dir_next  = dir_reg;
      if (lclk_fall) begin
         case (st_reg)
            pda_pkg::PDA_IDLE: begin
               // refresh wins over dma so memory is never starved
               if (refresh_req) begin
                  st_next = pda_pkg::PDA_REFRESH;
               end else if (pending != 8'h00) begin
                  ch_next  = pick(pending);
                  cnt_next = xfer_count;
                  dir_next = read_dir;
                  st_next  = pda_pkg::PDA_GRANT;
               end
            end
            pda_pkg::PDA_GRANT: begin
               if (!pending[ch_reg]) begin
                  st_next = pda_pkg::PDA_IDLE;
               end else begin
                  stb_next = pda_pkg::STROBE_CNT;
                  st_next  = pda_pkg::PDA_STROBE;
               end
            end
            pda_pkg::PDA_STROBE: begin
               if (stb_reg != 2'h0) begin
                  stb_next = stb_reg - 2'h1;
               end else begin
                  // halfword channels keep all 16 bits, byte channels the low 8
                  data_next = pda_pkg::CH_WIDE[ch_reg] ? bus.data : {8'h00, bus.data[7:0]};
                  st_next   = pda_pkg::PDA_RECOVER;
               end
            end
            pda_pkg::PDA_RECOVER: begin
               if (cnt_reg == 16'h0000 || !pending[ch_reg]) begin
                  st_next = pda_pkg::PDA_IDLE;
                  ch_next = pda_pkg::CH_NONE;
               end else begin
                  cnt_next = cnt_reg - 16'h0001;
                  st_next  = pda_pkg::PDA_GRANT;
               end
            end
            pda_pkg::PDA_REFRESH: begin
               if (!refresh_req) begin
                  st_next = pda_pkg::PDA_IDLE;
               end
            end
            default: begin
               st_next = pda_pkg::PDA_IDLE;
            end
         endcase
         if (st_reg == pda_pkg::PDA_GRANT && !pending[ch_reg]) begin
            ch_next = pda_pkg::CH_NONE;
         end
      end
      if (!rst_b) begin
         st_next   = pda_pkg::PDA_IDLE;
         ch_next   = pda_pkg::CH_NONE;
         cnt_next  = pda_pkg::CNT_RST;
         stb_next  = 2'h0;
         data_next = 16'h0000;
         dir_next  = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      st_reg   <= st_next;
      ch_reg   <= ch_next;
      cnt_reg  <= cnt_next;
      stb_reg  <= stb_next;
      data_reg <= data_next;
      dir_reg  <= dir_next;
   end

   // ****************************************
   // bus outputs, all from flops
   // ****************************************
   logic [7:0] dack_n_reg, dack_n_next;
   logic       aen_reg, aen_next, bale_reg, bale_next, tc_reg, tc_next;
   logic       ior_n_reg, ior_n_next, iow_n_reg, iow_n_next, ref_reg, ref_next;
   logic       dma_on, stb_on;

   assign dma_on = (st_next == pda_pkg::PDA_GRANT) || (st_next == pda_pkg::PDA_STROBE) ||
                   (st_next == pda_pkg::PDA_RECOVER);
   assign stb_on = st_next == pda_pkg::PDA_STROBE;

   always_comb begin
      dack_n_next = 8'hff;
      if (dma_on && ch_next != pda_pkg::CH_NONE) begin
         dack_n_next[ch_next] = 1'b0;
      end
      aen_next   = dma_on;
      bale_next  = dma_on || (st_next == pda_pkg::PDA_REFRESH);
      tc_next    = stb_on && (cnt_next == 16'h0000);
      ior_n_next = !(stb_on && dir_next);
      iow_n_next = !(stb_on && !dir_next);
      ref_next   = st_next == pda_pkg::PDA_REFRESH;
      if (!rst_b) begin
         dack_n_next = 8'hff;
         aen_next    = 1'b0;
         bale_next   = 1'b0;
         tc_next     = 1'b0;
         ior_n_next  = 1'b1;
         iow_n_next  = 1'b1;
         ref_next    = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      dack_n_reg <= dack_n_next;
      aen_reg    <= aen_next;
      bale_reg   <= bale_next;
      tc_reg     <= tc_next;
      ior_n_reg  <= ior_n_next;
      iow_n_reg  <= iow_n_next;
      ref_reg    <= ref_next;
   end

   // acknowledges driven at all times, even idle
   assign bus.dack_n       = dack_n_reg;
   assign bus.aen          = aen_reg;
   assign bus.bale         = bale_reg;
   assign bus.tc           = tc_reg;
   assign bus.ior_n        = ior_n_reg;
   assign bus.iow_n        = iow_n_reg;
   assign bus.refresh_n_o  = 1'b0;
   assign bus.refresh_n_oe = ref_reg;
   assign bus.bus_reset    = rdrv_on_reg;

   assign active_ch = ch_reg;
   assign last_data = data_reg;
   assign busy      = st_reg != pda_pkg::PDA_IDLE;

endmodule

// >>> hdl/pda_pkg.sv
package pda_pkg;

   // ****************************************
   // channel layout
   // ****************************************
   localparam int          NUM_CH        = 8;         // channel slots 0..7, slot 4 is the cascade, never wired
   localparam logic [7:0]  CH_PRESENT    = 8'hef;     // channels 0-3 and 5-7 attached
   localparam logic [7:0]  CH_WIDE       = 8'he0;     // channels 5-7 move 16-bit halfwords
   localparam logic [2:0]  CH_NONE       = 3'h4;      // grant code meaning no channel
   localparam int          CNT_W         = 16;        // transfer count width
   localparam logic [15:0] CNT_RST       = 16'h0000;  // transfer count after reset
   localparam logic [1:0]  SYNC_RST      = 2'h0;      // synchroniser value after reset
   localparam logic [2:0]  RSTDRV_CNT    = 3'h7;      // link periods the adapter reset outlasts rst_b

   // ****************************************
   // master transfer sequence
   // ****************************************
   typedef enum logic [2:0] {
      PDA_IDLE    = 3'h0,
      PDA_GRANT   = 3'h1,
      PDA_STROBE  = 3'h2,
      PDA_RECOVER = 3'h3,
      PDA_REFRESH = 3'h4
   } pda_state_e;

   localparam int          STROBE_CYC    = 2;         // link cycles a command strobe is held
   localparam logic [1:0]  STROBE_CNT    = 2'(STROBE_CYC - 1);

endpackage

// >>> test/pda_monitor.sv
`timescale 1ns/1ps
// watches the shared arbitration wires; master outputs move off link edges, so sampled values are settled
module pda_monitor (
   input wire logic       link_clk,   // bus clock from master
   input wire logic       bus_reset,  // adapter reset, high
   input wire logic [7:0] drq,        // resolved requests
   input wire logic [7:0] dack_n,     // acknowledges, low
   input wire logic       aen,        // address enable
   input wire logic       bale,       // latch enable
   input wire logic       tc,         // terminal count
   input wire logic       ior_n,      // read strobe
   input wire logic       iow_n,      // write strobe
   input wire logic       refresh_n   // resolved refresh line
);
   // ****************************************
   // clocking and grant steps
   // ****************************************
   default clocking cb @(posedge link_clk);
   endclocking
   default disable iff (bus_reset);

   // the request may already be falling when the grant shows, so look two samples back
   sequence s_grant;
      (~dack_n & ($past(drq) | $past(drq, 2))) != 8'h00;
   endsequence
   sequence s_held;
      $rose(aen) && ((~dack_n & drq) != 8'h00);
   endsequence
   sequence s_strobe;
      !ior_n || !iow_n;
   endsequence

   // ****************************************
   // checks
   // ****************************************
   AST_ONE_GRANT: assert property ($onehot0(~dack_n)) else $error("two acknowledges low");
   AST_NO_CASCADE: assert property (dack_n[4]) else $error("cascade slot acknowledged");
   AST_AEN_DACK: assert property (aen == (dack_n != 8'hff)) else $error("aen and grant disagree");
   AST_BALE_DMA: assert property (aen |-> bale) else $error("bale low during dma");
   AST_GRANT_REQ: assert property ($rose(aen) |-> s_grant) else $error("grant without request");
   AST_STROBE: assert property (s_held |-> ##[1:2] s_strobe) else $error("no strobe after grant");
   AST_STROBE_OWNER: assert property (s_strobe |-> aen && $onehot(~dack_n) && (ior_n || iow_n))
      else $error("strobe outside a grant");
   AST_TC_STROBE: assert property (tc |-> aen ##0 s_strobe) else $error("tc outside strobe");
   AST_REFRESH: assert property (!refresh_n |-> bale && !aen && (dack_n == 8'hff))
      else $error("refresh overlaps dma");
   AST_RELEASE: assert property ((aen && ((~dack_n & drq) == 8'h00)) |-> ##[1:6] !aen)
      else $error("grant held after request fell");
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
   // ****************************************
   // wiring
   // ****************************************
   logic        clock;
   logic        rst_b;
   logic [7:0]  chan_en;
   logic [15:0] xfer_count;
   logic        read_dir;
   logic        refresh_req;
   logic [7:0]  want;
   logic [15:0] wr_data;
   logic [2:0]  active_ch;
   logic [15:0] last_data;
   logic        busy;
   logic [7:0]  xfer_pulse;
   logic [7:0]  tc_pulse;
   logic        refresh_seen;
   int          errors;
   int          comparisons;
   int          seen_x;
   int          seen_tc;
   int          c;

   pda_bus_if bus ();
   pda_master #(.DIV(1)) u_pda_master (.bus(bus), .clock(clock), .rst_b(rst_b), .chan_en(chan_en),
      .xfer_count(xfer_count), .read_dir(read_dir), .refresh_req(refresh_req), .active_ch(active_ch),
      .last_data(last_data), .busy(busy));
   pda_adapter u_pda_adapter (.bus(bus), .clock(clock), .rst_b(rst_b), .want(want), .wr_data(wr_data),
      .xfer_pulse(xfer_pulse), .tc_pulse(tc_pulse), .refresh_seen(refresh_seen));
   pda_monitor u_pda_monitor (.link_clk(bus.link_clk), .bus_reset(bus.bus_reset), .drq(bus.drq),
      .dack_n(bus.dack_n), .aen(bus.aen), .bale(bus.bale), .tc(bus.tc), .ior_n(bus.ior_n),
      .iow_n(bus.iow_n), .refresh_n(bus.refresh_n));

   // 50 MHz system clock
   always #10 clock = ~clock;

   // ****************************************
   // helpers
   // ****************************************
   task automatic tick();
      @(posedge clock);
      #2;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("comparisons %0d, errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // a stale request may earn one short regrant, so wait for a quiet stretch
   task automatic settle();
      int n;
      int q;
      q = 0;
      for (n = 0; n < 400 && q < 12; n++) begin
         tick();
         q = (busy === 1'b0) ? q + 1 : 0;
      end
      check(16'(active_ch), 16'(pda_pkg::CH_NONE));
   endtask

   // one burst seen from the adapter: raise requests, count transfers until terminal count
   task automatic xfer(input logic [7:0] mask, input logic [2:0] ch, input logic [15:0] cnt,
                       input logic rd, input logic [15:0] dat);
      int n;
      seen_x = 0;
      seen_tc = 0;
      xfer_count = cnt;
      read_dir = rd;
      wr_data = dat;
      want = mask;
      for (n = 0; n < 300 && active_ch === pda_pkg::CH_NONE; n++) tick();
      tick();
      check(16'(active_ch), 16'(ch));
      check(16'(bus.dack_n), {8'h00, ~(8'h01 << ch)});
      check(16'({bus.aen, bus.bale}), 16'h0003);
      for (n = 0; n < 2000 && seen_tc == 0; n++) begin
         tick();
         seen_x += xfer_pulse[ch];
         seen_tc += tc_pulse[ch];
      end
      want = 8'h00;
      check(16'(seen_x), cnt + 16'h0001);
      if (rd) check(last_data, (ch < 3'h4) ? {8'h00, dat[7:0]} : dat);
      settle();
      $display("burst on channel %0d finished", ch);
   endtask

   // ****************************************
   // tests
   // ****************************************
   initial begin
      clock = 1'b0;
      rst_b = 1'b0;
      chan_en = 8'hff;
      xfer_count = 16'h0000;
      read_dir = 1'b1;
      refresh_req = 1'b0;
      want = 8'h00;
      wr_data = 16'h0000;
      errors = 0;
      comparisons = 0;
      repeat (6) tick();
      rst_b = 1'b1;
      check(16'(bus.dack_n), 16'h00ff);
      check(16'({busy, active_ch}), 16'(pda_pkg::CH_NONE));
      $display("reset test finished");
      // every attached channel, counts 0..3, reads and writes
      for (c = 0; c < 8; c++) begin
         if (c != 4) xfer(8'h01 << c, 3'(c), 16'(c % 4), 1'(c & 1), 16'ha5c3 + 16'(c));
      end
      // simultaneous requests: lowest number wins
      xfer(8'h48, 3'h3, 16'h0002, 1'b1, 16'h1234);
      xfer(8'he0, 3'h5, 16'h0001, 1'b1, 16'hbeef);
      // disabled channel and cascade slot never granted
      chan_en = 8'hfd;
      want = 8'h12;
      seen_x = 0;
      for (c = 0; c < 100; c++) begin
         tick();
         seen_x += (active_ch !== pda_pkg::CH_NONE || bus.dack_n !== 8'hff);
      end
      check(16'(seen_x), 16'h0000);
      want = 8'h00;
      // let the disabled request fall before enabling the channel again
      repeat (20) tick();
      chan_en = 8'hff;
      $display("refusal test finished");
      // request dropped in mid-burst: no terminal count, grant released
      xfer_count = 16'h0005;
      want = 8'h04;
      seen_tc = 0;
      for (c = 0; c < 400 && xfer_pulse[2] !== 1'b1; c++) tick();
      want = 8'h00;
      for (c = 0; c < 200; c++) begin
         tick();
         seen_tc += tc_pulse[2];
      end
      check(16'(seen_tc), 16'h0000);
      settle();
      $display("abort test finished");
      // refresh cycle: line low, latch enable high, no address enable
      refresh_req = 1'b1;
      for (c = 0; c < 100 && refresh_seen !== 1'b1; c++) tick();
      check(16'({refresh_seen, bus.refresh_n, bus.bale, bus.aen, busy}), 16'h0015);
      refresh_req = 1'b0;
      for (c = 0; c < 100 && refresh_seen !== 1'b0; c++) tick();
      check(16'({refresh_seen, bus.refresh_n}), 16'h0001);
      $display("refresh test finished");
      results();
   end

   // watchdog, several times the few tens of microseconds the tests take
   initial begin
      #200000;
      errors++;
      results();
   end
endmodule
